// *** rtl/bsr_core_if.sv ***
`timescale 1ns/1ps
interface bsr_core_if #(
    parameter int unsigned W = 8
);
    bsr_pkg::bsr_mode_t mode;
    logic               ce;
    logic               advance;
    logic               clr;
    logic               ser_r;
    logic               ser_l;
    logic [W-1:0]       pdata;
    logic [W-1:0]       stages;

    modport ctl (
        output mode, ce, advance, clr, ser_r, ser_l, pdata,
        input  stages
    );
    modport core (
        input  mode, ce, advance, clr, ser_r, ser_l, pdata,
        output stages
    );
    modport drv (
        input  mode, stages
    );
endinterface : bsr_core_if

// *** rtl/bsr_pkg.sv ***
package bsr_pkg;

    localparam int unsigned BSR_WIDTH       = 8;
    localparam int unsigned BSR_ADDR_W      = 4;

    // ----------------------------------------------------------------
    // Register map
    // ----------------------------------------------------------------
    localparam logic [3:0]  BSR_OFS_CTRL    = 4'h0;
    localparam logic [3:0]  BSR_OFS_CMD     = 4'h4;
    localparam logic [3:0]  BSR_OFS_STAT    = 4'h8;
    localparam logic [3:0]  BSR_OFS_PINS    = 4'hc;

    localparam int unsigned CTRL_SRC_BIT    = 0;
    localparam int unsigned CTRL_MODE_LSB   = 1;
    localparam int unsigned CTRL_DRVOFF_BIT = 3;
    localparam int unsigned CMD_STEP_BIT    = 0;
    localparam int unsigned CMD_CLR_BIT     = 1;
    localparam int unsigned CMD_DATA_LSB    = 8;
    localparam int unsigned STAT_FTAP_BIT   = 8;
    localparam int unsigned STAT_LTAP_BIT   = 9;
    localparam int unsigned STAT_MODE_LSB   = 10;
    localparam int unsigned STAT_DRIVE_BIT  = 12;
    localparam int unsigned PINS_SER_R_BIT  = 8;
    localparam int unsigned PINS_SER_L_BIT  = 9;

    localparam logic [7:0]  CTRL_RST        = 8'h00;
    localparam logic [7:0]  DATA_RST        = 8'h00;

    localparam logic [1:0]  RESP_OKAY       = 2'h0;
    localparam logic [1:0]  RESP_SLVERR     = 2'h2;

    // Code is {high bit, low bit} of the mode select
    typedef enum logic [1:0] {
        BSR_HOLD  = 2'b00,
        BSR_SHR   = 2'b01,
        BSR_SHL   = 2'b10,
        BSR_LOAD  = 2'b11
    } bsr_mode_t;

endpackage : bsr_pkg

// *** rtl/bsr_port_drv.sv ***
`timescale 1ns/1ps
module bsr_port_drv #(
    parameter int unsigned W = 8
) (
    bsr_core_if.drv          cif,
    input  wire logic        port_drive_en_n_a,
    input  wire logic        port_drive_en_n_b,
    input  wire logic        drive_off,
    output logic             port_driven,
    output logic [W-1:0]     port_line_out,
    output logic [W-1:0]     port_line_oe
);

    // ----------------------------------------------------------------
    // Port drive decision
    // ----------------------------------------------------------------
    always_comb begin
        port_driven = !port_drive_en_n_a && !port_drive_en_n_b
                      && (cif.mode != bsr_pkg::BSR_LOAD)
                      && !drive_off;
        port_line_out = cif.stages;
        port_line_oe  = {W{port_driven}};
    end

endmodule : bsr_port_drv

// *** rtl/bsr_shift_core.sv ***
`timescale 1ns/1ps
module bsr_shift_core #(
    parameter int unsigned W = 8
) (
    input  wire logic  aclk,
    input  wire logic  aresetn,
    input  wire logic  clear_n,
    bsr_core_if.core   cif
);

    typedef struct packed {
        logic [W-1:0] stages;
    } bsr_core_st_t;

    bsr_core_st_t st_ff;
    bsr_core_st_t nxt_st;

    // ----------------------------------------------------------------
    // Next stage values
    // ----------------------------------------------------------------
    always_comb begin
        nxt_st = st_ff;
        if (!aresetn) begin
            nxt_st.stages = '0;
        end else if (cif.ce) begin
            if (cif.clr) begin
                nxt_st.stages = '0;
            end else if (cif.advance) begin
                unique case (cif.mode)
                    bsr_pkg::BSR_HOLD: nxt_st.stages = st_ff.stages;
                    bsr_pkg::BSR_SHR:  nxt_st.stages = {st_ff.stages[W-2:0], cif.ser_r};
                    bsr_pkg::BSR_SHL:  nxt_st.stages = {cif.ser_l, st_ff.stages[W-1:1]};
                    bsr_pkg::BSR_LOAD: nxt_st.stages = cif.pdata;
                endcase
            end
        end
    end

    // Clear pin acts without the clock
    always_ff @(posedge aclk or negedge clear_n) begin
        if (!clear_n) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign cif.stages = st_ff.stages;

endmodule : bsr_shift_core

// *** rtl/bsr_top.sv ***
// The placing of the registers and register access over AXI4-Lite were decided locally.
`timescale 1ns/1ps
module bsr_top #(
    parameter int unsigned W      = bsr_pkg::BSR_WIDTH,
    parameter int unsigned ADDR_W = bsr_pkg::BSR_ADDR_W
) (
    input  wire logic              aclk,
    input  wire logic              aresetn,
    input  wire logic              ce,
    input  wire logic              clear_n,
    // AXI4-Lite slave
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,
    input  wire logic [2:0]        s_axi_awprot,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    input  wire logic [ADDR_W-1:0] s_axi_araddr,
    input  wire logic [2:0]        s_axi_arprot,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    // Device pins
    input  wire logic              mode_sel_low_bit,
    input  wire logic              mode_sel_high_bit,
    input  wire logic              port_drive_en_n_a,
    input  wire logic              port_drive_en_n_b,
    input  wire logic              serial_in_rightward,
    input  wire logic              serial_in_leftward,
    input  wire logic [W-1:0]      port_line_in,
    output logic [W-1:0]           port_line_out,
    output logic [W-1:0]           port_line_oe,
    output logic                   first_stage_tap,
    output logic                   last_stage_tap
);

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    typedef struct packed {
        logic                   aw_got;
        logic [ADDR_W-1:0]      aw_addr;
        logic                   w_got;
        logic [31:0]            w_data;
        logic [3:0]             w_strb;
        logic                   bvalid;
        logic [1:0]             bresp;
        logic                   rvalid;
        logic [31:0]            rdata;
        logic [1:0]             rresp;
        logic                   sw_src;
        bsr_pkg::bsr_mode_t     sw_mode;
        logic                   drv_off;
        logic                   step;
        logic                   clr;
        logic [W-1:0]           sw_data;
    } bsr_top_st_t;

    bsr_top_st_t st_ff;
    bsr_top_st_t nxt_st;

    bsr_core_if #(.W(W)) cif ();

    bsr_pkg::bsr_mode_t pin_mode;
    bsr_pkg::bsr_mode_t eff_mode;
    logic               port_driven;
    logic               aw_hs;
    logic               w_hs;
    logic               ar_hs;
    logic               wr_commit;
    logic [31:0]        rd_word;
    logic               rd_hit;

    // ----------------------------------------------------------------
    // Mode selection
    // ----------------------------------------------------------------
    always_comb begin
        pin_mode = bsr_pkg::bsr_mode_t'({mode_sel_high_bit, mode_sel_low_bit});
        eff_mode = st_ff.sw_src ? st_ff.sw_mode : pin_mode;
    end

    assign cif.mode    = eff_mode;
    assign cif.ce      = ce;
    assign cif.advance = st_ff.sw_src ? st_ff.step : 1'b1;
    assign cif.clr     = st_ff.clr;
    assign cif.ser_r   = serial_in_rightward;
    assign cif.ser_l   = serial_in_leftward;
    assign cif.pdata   = st_ff.sw_src ? st_ff.sw_data : port_line_in;

    // ----------------------------------------------------------------
    // Shift register and port drivers
    // ----------------------------------------------------------------
    bsr_shift_core #(
        .W (W)
    ) u_core (
        .aclk    (aclk),
        .aresetn (aresetn),
        .clear_n (clear_n),
        .cif     (cif.core)
    );

    bsr_port_drv #(
        .W (W)
    ) u_drv (
        .cif               (cif.drv),
        .port_drive_en_n_a (port_drive_en_n_a),
        .port_drive_en_n_b (port_drive_en_n_b),
        .drive_off         (st_ff.drv_off),
        .port_driven       (port_driven),
        .port_line_out     (port_line_out),
        .port_line_oe      (port_line_oe)
    );

    assign first_stage_tap = cif.stages[0];
    assign last_stage_tap  = cif.stages[W-1];

    // ----------------------------------------------------------------
    // Bus handshakes
    // ----------------------------------------------------------------
    assign s_axi_awready = ce && !st_ff.aw_got && !st_ff.bvalid;
    assign s_axi_wready  = ce && !st_ff.w_got && !st_ff.bvalid;
    assign s_axi_arready = ce && !st_ff.rvalid;
    assign s_axi_bvalid  = st_ff.bvalid;
    assign s_axi_bresp   = st_ff.bresp;
    assign s_axi_rvalid  = st_ff.rvalid;
    assign s_axi_rdata   = st_ff.rdata;
    assign s_axi_rresp   = st_ff.rresp;

    assign aw_hs     = s_axi_awvalid && s_axi_awready;
    assign w_hs      = s_axi_wvalid && s_axi_wready;
    assign ar_hs     = s_axi_arvalid && s_axi_arready;
    assign wr_commit = st_ff.aw_got && st_ff.w_got && !st_ff.bvalid;

    // ----------------------------------------------------------------
    // Read decode
    // ----------------------------------------------------------------
    always_comb begin
        rd_word = 32'h0000_0000;
        rd_hit  = 1'b1;
        unique case (s_axi_araddr[3:0])
            bsr_pkg::BSR_OFS_CTRL: begin
                rd_word[bsr_pkg::CTRL_SRC_BIT]    = st_ff.sw_src;
                rd_word[bsr_pkg::CTRL_MODE_LSB +: 2] = st_ff.sw_mode;
                rd_word[bsr_pkg::CTRL_DRVOFF_BIT] = st_ff.drv_off;
            end
            bsr_pkg::BSR_OFS_CMD: begin
                rd_word[bsr_pkg::CMD_DATA_LSB +: W] = st_ff.sw_data;
            end
            bsr_pkg::BSR_OFS_STAT: begin
                rd_word[W-1:0]                       = cif.stages;
                rd_word[bsr_pkg::STAT_FTAP_BIT]      = first_stage_tap;
                rd_word[bsr_pkg::STAT_LTAP_BIT]      = last_stage_tap;
                rd_word[bsr_pkg::STAT_MODE_LSB +: 2] = eff_mode;
                rd_word[bsr_pkg::STAT_DRIVE_BIT]     = port_driven;
            end
            bsr_pkg::BSR_OFS_PINS: begin
                rd_word[W-1:0]                    = port_line_in;
                rd_word[bsr_pkg::PINS_SER_R_BIT]  = serial_in_rightward;
                rd_word[bsr_pkg::PINS_SER_L_BIT]  = serial_in_leftward;
            end
            default: begin
                rd_hit = 1'b0;
            end
        endcase
    end

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb begin
        nxt_st = st_ff;
        if (!aresetn) begin
            nxt_st         = '0;
            nxt_st.sw_src  = bsr_pkg::CTRL_RST[bsr_pkg::CTRL_SRC_BIT];
            nxt_st.sw_mode = bsr_pkg::bsr_mode_t'(bsr_pkg::CTRL_RST[bsr_pkg::CTRL_MODE_LSB +: 2]);
            nxt_st.drv_off = bsr_pkg::CTRL_RST[bsr_pkg::CTRL_DRVOFF_BIT];
            nxt_st.sw_data = bsr_pkg::DATA_RST;
        end else if (ce) begin
            // Command pulses last one enabled cycle
            nxt_st.step = 1'b0;
            nxt_st.clr  = 1'b0;

            if (aw_hs) begin
                nxt_st.aw_got  = 1'b1;
                nxt_st.aw_addr = s_axi_awaddr;
            end
            if (w_hs) begin
                nxt_st.w_got  = 1'b1;
                nxt_st.w_data = s_axi_wdata;
                nxt_st.w_strb = s_axi_wstrb;
            end

            if (wr_commit) begin
                nxt_st.aw_got = 1'b0;
                nxt_st.w_got  = 1'b0;
                nxt_st.bvalid = 1'b1;
                nxt_st.bresp  = bsr_pkg::RESP_OKAY;
                unique case (st_ff.aw_addr[3:0])
                    bsr_pkg::BSR_OFS_CTRL: begin
                        if (st_ff.w_strb[0]) begin
                            nxt_st.sw_src  = st_ff.w_data[bsr_pkg::CTRL_SRC_BIT];
                            nxt_st.sw_mode = bsr_pkg::bsr_mode_t'(
                                st_ff.w_data[bsr_pkg::CTRL_MODE_LSB +: 2]);
                            nxt_st.drv_off = st_ff.w_data[bsr_pkg::CTRL_DRVOFF_BIT];
                        end
                    end
                    bsr_pkg::BSR_OFS_CMD: begin
                        if (st_ff.w_strb[1]) begin
                            nxt_st.sw_data = st_ff.w_data[bsr_pkg::CMD_DATA_LSB +: W];
                        end
                        if (st_ff.w_strb[0]) begin
                            nxt_st.step = st_ff.w_data[bsr_pkg::CMD_STEP_BIT];
                            nxt_st.clr  = st_ff.w_data[bsr_pkg::CMD_CLR_BIT];
                        end
                    end
                    bsr_pkg::BSR_OFS_STAT,
                    bsr_pkg::BSR_OFS_PINS: begin
                        nxt_st.bresp = bsr_pkg::RESP_OKAY;
                    end
                    default: begin
                        nxt_st.bresp = bsr_pkg::RESP_SLVERR;
                    end
                endcase
            end else if (st_ff.bvalid && s_axi_bready) begin
                nxt_st.bvalid = 1'b0;
            end

            if (ar_hs) begin
                nxt_st.rvalid = 1'b1;
                nxt_st.rdata  = rd_word;
                nxt_st.rresp  = rd_hit ? bsr_pkg::RESP_OKAY : bsr_pkg::RESP_SLVERR;
            end else if (st_ff.rvalid && s_axi_rready) begin
                nxt_st.rvalid = 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        st_ff <= nxt_st;
    end

endmodule : bsr_top

// *** tb/bsr_bus_partner.sv ***
`timescale 1ns/1ps
module bsr_bus_partner #(
    parameter int unsigned W = 8
) (
    input wire logic         aclk,
    input wire logic [W-1:0] port_line_out,
    input wire logic [W-1:0] port_line_oe,
    input wire logic         drive_en,
    input wire logic [W-1:0] drive_data,
    output logic [W-1:0]     port_level,
    output logic             clash
);
    logic [W-1:0] last_ff = '0;
    // Lines that neither side drives show the inverse of their last level; with drive_en they show drive_data
    assign port_level = (port_line_oe & port_line_out) |
                        (~port_line_oe & (drive_en ? drive_data : ~last_ff));
    assign clash = drive_en && (port_line_oe != '0);
    always_ff @(posedge aclk) begin
        last_ff <= port_level;
    end
endmodule : bsr_bus_partner

// *** tb/bsr_top_chk.sv ***
`timescale 1ns/1ps
module bsr_top_chk #(
    parameter int unsigned W = 8
) (
    input wire logic         aclk,
    input wire logic         aresetn,
    input wire logic         ce,
    input wire logic         clear_n,
    input wire logic         mode_sel_low_bit,
    input wire logic         mode_sel_high_bit,
    input wire logic         port_drive_en_n_a,
    input wire logic         port_drive_en_n_b,
    input wire logic         serial_in_rightward,
    input wire logic         serial_in_leftward,
    input wire logic [W-1:0] port_line_in,
    input wire logic [W-1:0] port_line_out,
    input wire logic [W-1:0] port_line_oe,
    input wire logic         first_stage_tap,
    input wire logic         last_stage_tap
);
    logic [1:0] md;
    assign md = {mode_sel_high_bit, mode_sel_low_bit};

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn || !clear_n);

    // ----
    // Register and port drive behaviour
    // ----
    property p_hold;
        (aresetn && clear_n && (!ce || md == 2'b00)) |=> $stable(port_line_out);
    endproperty
    a_hold: assert property (p_hold) else $error("stages moved in hold");
    property p_shr;
        (aresetn && clear_n && ce && md == 2'b01) |=>
            port_line_out == {$past(port_line_out[W-2:0]), $past(serial_in_rightward)};
    endproperty
    a_shr: assert property (p_shr) else $error("shift right wrong");
    property p_shl;
        (aresetn && clear_n && ce && md == 2'b10) |=>
            port_line_out == {$past(serial_in_leftward), $past(port_line_out[W-1:1])};
    endproperty
    a_shl: assert property (p_shl) else $error("shift left wrong");
    property p_load;
        (aresetn && clear_n && ce && md == 2'b11) |=> port_line_out == $past(port_line_in);
    endproperty
    a_load: assert property (p_load) else $error("parallel load wrong");
    property p_float;
        md == 2'b11 |-> port_line_oe == '0;
    endproperty
    a_float: assert property (p_float) else $error("port driven in load");
    property p_drive;
        port_line_oe != '0 |->
            (port_line_oe == '1 && !port_drive_en_n_a && !port_drive_en_n_b && md != 2'b11);
    endproperty
    a_drive: assert property (p_drive) else $error("port driven wrongly");
    property p_clear;
        disable iff (!aresetn)
        !clear_n |-> (port_line_out == '0 && !first_stage_tap && !last_stage_tap);
    endproperty
    a_clear: assert property (p_clear) else $error("clear did not empty stages");
    property p_taps;
        first_stage_tap == port_line_out[0] && last_stage_tap == port_line_out[W-1];
    endproperty
    a_taps: assert property (p_taps) else $error("taps differ from stages");
    c_load: cover property (ce && md == 2'b11);
    c_shr: cover property (ce && md == 2'b01 && port_line_oe == '1);
    c_shl: cover property (ce && md == 2'b10);
endmodule : bsr_top_chk

// *** tb/testbench.sv ***
`timescale 1ns/1ps
module testbench;
    logic        aclk, aresetn, ce, clear_n, awvalid, wvalid, bready, arvalid, rready;
    logic        awready, wready, bvalid, arready, rvalid, ml, mh, ena, enb, sr, sl;
    logic        ftap, ltap, pdrv, clash;
    logic [3:0]  awaddr, araddr, wstrb;
    logic [31:0] wdata, rdata, lfsr, rv;
    logic [1:0]  bresp, rresp, rsp, m;
    logic [7:0]  pin, pout, poe, pdat, exps;
    int          err_total, comparisons;
    typedef struct packed {logic wr; logic [3:0] a; logic [31:0] d; logic [1:0] r;} bsr_step_t;
    bsr_step_t   steps [11] = '{'{1'b0, 4'h0, 32'h0, 2'h0}, '{1'b0, 4'h4, 32'h0, 2'h0},
        '{1'b1, 4'h0, 32'hf, 2'h0}, '{1'b0, 4'h0, 32'hf, 2'h0}, '{1'b1, 4'h0, 32'h0, 2'h0},
        '{1'b1, 4'h4, 32'ha500, 2'h0}, '{1'b0, 4'h4, 32'ha500, 2'h0},
        '{1'b1, 4'h6, 32'h0, 2'h2}, '{1'b0, 4'h6, 32'h0, 2'h2},
        '{1'b1, 4'h8, 32'hffff, 2'h0}, '{1'b0, 4'hc, 32'h13c, 2'h0}};

    bsr_top dut (.aclk(aclk), .aresetn(aresetn), .ce(ce), .clear_n(clear_n),
        .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .mode_sel_low_bit(ml), .mode_sel_high_bit(mh), .port_drive_en_n_a(ena),
        .port_drive_en_n_b(enb), .serial_in_rightward(sr), .serial_in_leftward(sl),
        .port_line_in(pin), .port_line_out(pout), .port_line_oe(poe),
        .first_stage_tap(ftap), .last_stage_tap(ltap));
    bsr_bus_partner u_far (.aclk(aclk), .port_line_out(pout), .port_line_oe(poe),
        .drive_en(pdrv), .drive_data(pdat), .port_level(pin), .clash(clash));

    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr_next
    function automatic logic [7:0] step_of(input logic [7:0] s, input logic [1:0] md,
                                           input logic r, input logic l, input logic [7:0] p);
        case (md)
            2'b01:   return {s[6:0], r};
            2'b10:   return {l, s[7:1]};
            2'b11:   return p;
            default: return s;
        endcase
    endfunction : step_of

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_total++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    task automatic close_out();
        $display("errors %0d comparisons %0d", err_total, comparisons);
        if (err_total == 0 && comparisons > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : close_out

    // ----
    // AXI4-Lite master
    // ----
    task automatic wait_ans(input bit rd);
        logic got;
        got = 1'b0;
        while (!got) begin
            @(negedge aclk);
            got = rd ? rvalid : bvalid;
            rsp = rd ? rresp : bresp;
            rv = rdata;
            @(posedge aclk);
        end
        bready <= 1'b0;
        rready <= 1'b0;
        @(posedge aclk);
    endtask : wait_ans
    task automatic axi_wr(input logic [3:0] a, input logic [31:0] d);
        logic ad, wd;
        ad = 1'b0;
        wd = 1'b0;
        {awaddr, wdata, wstrb} <= {a, d, 4'hf};
        {awvalid, wvalid} <= 2'b11;
        while (!(ad && wd)) begin
            @(negedge aclk);
            ad = ad || awready;
            wd = wd || wready;
            @(posedge aclk);
            awvalid <= !ad;
            wvalid <= !wd;
        end
        bready <= 1'b1;
        wait_ans(1'b0);
    endtask : axi_wr
    task automatic axi_rd(input logic [3:0] a);
        logic ad;
        ad = 1'b0;
        araddr <= a;
        {arvalid, rready} <= 2'b11;
        while (!ad) begin
            @(negedge aclk);
            ad = arready;
            @(posedge aclk);
            arvalid <= !ad;
        end
        wait_ans(1'b1);
    endtask : axi_rd

    initial begin
        aclk = 1'b0;
        forever #2.5 aclk = ~aclk;
    end
    initial begin
        #100000;
        err_total++;
        close_out();
    end
    initial begin
        {aresetn, awvalid, wvalid, bready, arvalid, rready, ml, mh, ena, enb, sr, sl} = '0;
        {awaddr, araddr, wstrb, wdata, pdat, exps, m} = '0;
        {ce, clear_n, pdrv} = 3'b110;
        {err_total, comparisons} = '0;
        lfsr = 32'ha802;
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        for (int i = 0; i < 1500; i++) begin
            lfsr = lfsr_next(lfsr);
            m = (i == 0) ? 2'b11 : (i < 9) ? 2'b01 : lfsr[1:0];
            {mh, ml} <= m;
            ena <= lfsr[2] & lfsr[3];
            enb <= lfsr[4] & lfsr[5];
            {sr, sl} <= lfsr[7:6];
            ce <= (i < 9) || (|lfsr[10:8]);
            pdat <= lfsr[23:16];
            pdrv <= (m == 2'b11) || (lfsr[11] && (&lfsr[3:2] || &lfsr[5:4]));
            aresetn <= (i < 750 || i > 751);
            @(negedge aclk);
            check("stages", 32'(pout), 32'(exps));
            check("taps", 32'({ltap, ftap}), 32'({exps[7], exps[0]}));
            check("oe", 32'(poe), (!ena && !enb && m != 2'b11) ? 32'hff : 32'h0);
            check("clash", 32'(clash), 32'h0);
            if (lfsr[31:27] == 5'h0) begin
                clear_n = 1'b0;
                #1;
                check("clear", 32'({pout, ltap, ftap}), 32'h0);
                exps = 8'h00;
            end else if (!aresetn) begin
                exps = 8'h00;
            end else if (ce) begin
                exps = step_of(exps, m, sr, sl, pin);
            end
            @(posedge aclk);
            clear_n <= 1'b1;
        end
        {mh, ml, ena, enb, sr, sl, pdrv, ce} <= 8'b00111011;
        pdat <= 8'h3c;
        @(posedge aclk);
        foreach (steps[k]) begin
            if (steps[k].wr) axi_wr(steps[k].a, steps[k].d);
            else axi_rd(steps[k].a);
            check("resp", 32'(rsp), 32'(steps[k].r));
            if (!steps[k].wr) check("rdata", rv, steps[k].d);
        end
        axi_rd(4'h8);
        check("status", rv, {22'h0, exps[7], exps[0], exps});
        {ena, enb, pdrv} <= 3'b000;
        axi_wr(4'h0, 32'h8);
        @(negedge aclk);
        check("drv_off", 32'(poe), 32'h0);
        @(posedge aclk);
        axi_wr(4'h0, 32'h0);
        @(negedge aclk);
        check("oe_on", 32'(poe), 32'hff);
        check("clash_on", 32'(clash), 32'h0);
        @(posedge aclk);
        close_out();
    end
endmodule : testbench

bind bsr_top bsr_top_chk #(.W(W)) u_chk (.aclk(aclk), .aresetn(aresetn), .ce(ce),
    .clear_n(clear_n), .mode_sel_low_bit(mode_sel_low_bit),
    .mode_sel_high_bit(mode_sel_high_bit), .port_drive_en_n_a(port_drive_en_n_a),
    .port_drive_en_n_b(port_drive_en_n_b), .serial_in_rightward(serial_in_rightward),
    .serial_in_leftward(serial_in_leftward), .port_line_in(port_line_in),
    .port_line_out(port_line_out), .port_line_oe(port_line_oe),
    .first_stage_tap(first_stage_tap), .last_stage_tap(last_stage_tap));
